// file: hdl/cobadr_pkg.sv
// Constants, enumerations and helpers for the operand and branch addressing core.
// Assumes a decoder ahead of it and synchronous data and program memories behind it.
// How it works
// - Indirect operand comes from first or second pointer
// - Load or exchange then steps pointer by one
// - Direct mode uses 8-bit address field
// - Immediate mode uses 8-bit instruction field
// - Short pointer load carries 4-bit constant
// - ROM byte at high part and accumulator
// - Relative jump adds -31..+32 to program counter
// - Absolute jump or call replaces low 12 bits
// - Long jump or call loads all 15 bits
// - Table jump loads ROM byte into low part
// - Program counter is 7-bit high, 8-bit low
// - Register operands sit at F0 to FF
// - Decrement register, skip when it reaches zero
// - Equal or greater test gates next instruction
// - Pointer low nibble mismatch gates next instruction
// - Set or clear selected memory bit
// - Bit test gates next instruction on one
// - Add or subtract with carry, set both carries
// - Logical ops combine accumulator with operand
package cobadr_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 15;
  localparam int LOW_W = 8;
  localparam int HIGH_W = 7;
  localparam int ABS_W = 12;
  localparam int SHORT_W = 4;
  localparam logic [3:0] REG_PAGE = 4'hf;
  localparam logic [7:0] ADDR_SECOND = 8'hfc;
  localparam logic [7:0] ADDR_STACK = 8'hfd;
  localparam logic [7:0] ADDR_FIRST = 8'hfe;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] STACK_RESET = 8'h6f;
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic signed [6:0] DISP_MIN = -7'sd31;
  localparam logic signed [6:0] DISP_MAX = 7'sd32;
  localparam logic [7:0] BCD_LOW_FIX = 8'h06;
  localparam logic [7:0] BCD_HIGH_FIX = 8'h60;
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] BCD_BYTE_MAX = 8'h99;

  typedef enum logic [4:0] {
    op_add_carry, op_sub_borrow, op_and, op_or, op_xor,
    op_test_equal, op_test_greater, op_test_pointer_low_ne,
    op_dec_reg_skip_zero, op_set_mem_bit, op_clear_mem_bit, op_test_mem_bit,
    op_load_acc, op_load_mem_imm, op_exchange, op_load_ptr_short,
    op_load_acc_from_rom, op_jump_short_rel, op_jump_absolute, op_call_absolute,
    op_jump_long, op_call_long, op_jump_via_table, op_decimal_adjust
  } cobadr_op_t;

  typedef enum logic [1:0] {mode_indirect, mode_direct, mode_immediate, mode_reg} cobadr_mode_t;

  typedef enum logic [1:0] {post_none, post_inc, post_dec} cobadr_post_t;

  // Operand byte needed from data memory or the internal register page
  function automatic logic needs_operand(input cobadr_op_t op);
    case (op)
      op_add_carry, op_sub_borrow, op_and, op_or, op_xor, op_test_equal, op_test_greater,
      op_dec_reg_skip_zero, op_set_mem_bit, op_clear_mem_bit, op_test_mem_bit,
      op_load_acc, op_exchange: needs_operand = 1'b1;
      default: needs_operand = 1'b0;
    endcase
  endfunction

  function automatic logic is_internal(input logic [7:0] addr);
    is_internal = (addr == ADDR_FIRST) || (addr == ADDR_SECOND) || (addr == ADDR_STACK);
  endfunction

  function automatic logic [14:0] pc_plus(input logic [14:0] pc, input logic [1:0] len);
    pc_plus = pc + {13'h0000, len};
  endfunction
endpackage

// file: hdl/cobadr_core.sv
// Execution core for operand addressing, arithmetic, tests and control transfer.
// Assumes decoded operations arrive one at a time and both memories answer one cycle after a read strobe.
`timescale 1ns/10ps
module cobadr_core (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Decoded operation
  input wire logic op_valid,
  output logic op_ready,
  input wire cobadr_pkg::cobadr_op_t op_code,
  input wire cobadr_pkg::cobadr_mode_t op_mode,
  input wire logic op_ptr_sel,
  input wire cobadr_pkg::cobadr_post_t op_post,
  input wire logic [7:0] op_imm,
  input wire logic [7:0] op_addr,
  input wire logic [2:0] op_bit,
  input wire logic signed [6:0] op_disp,
  input wire logic [14:0] op_target,
  input wire logic [1:0] op_len,
  // Completion
  output logic op_done,
  output logic skip_next,
  // Data memory
  output logic [7:0] dmem_addr,
  output logic dmem_rd,
  output logic dmem_wr,
  output logic [7:0] dmem_wdata,
  input wire logic [7:0] dmem_rdata,
  // Program memory
  output logic [14:0] pmem_addr,
  output logic pmem_rd,
  input wire logic [7:0] pmem_rdata,
  // Architectural state
  output logic [14:0] program_counter,
  output logic [7:0] accumulator,
  output logic carry,
  output logic half_carry,
  output logic [7:0] first_pointer,
  output logic [7:0] second_pointer,
  output logic [7:0] stack_pointer
);
  import cobadr_pkg::*;

  typedef enum logic [2:0] {s_idle, s_wait, s_exec, s_push, s_write} cobadr_state_t;

  cobadr_state_t state;
  cobadr_op_t cur_op;
  cobadr_mode_t cur_mode;
  cobadr_post_t cur_post;
  logic cur_ptr_sel;
  logic [7:0] cur_imm;
  logic [7:0] cur_ea;
  logic [2:0] cur_bit;
  logic signed [6:0] cur_disp;
  logic [14:0] cur_target;
  logic [14:0] cur_ret;
  logic cur_internal;
  logic cur_from_mem;
  logic cur_from_rom;
  logic [7:0] hold;
  logic last_sub;

  logic accept;
  logic [7:0] ea;
  logic acc_read;
  logic is_call;
  logic [7:0] opnd;
  logic [7:0] ex_res;
  logic [7:0] ex_acc;
  logic ex_acc_we;
  logic ex_flags_we;
  logic ex_c;
  logic ex_hc;
  logic ex_wr;
  logic ex_skip;
  logic [14:0] ex_pc;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] addend;
  logic [7:0] fix;
  logic hi_fix;

  assign accept = op_valid && op_ready;
  assign acc_read = needs_operand(op_code) && (op_mode != mode_immediate);
  assign is_call = (cur_op == op_call_absolute) || (cur_op == op_call_long);

  // Effective data address of a new operation
  always_comb begin
    case (op_mode)
      mode_direct: ea = op_addr;
      mode_reg: ea = {REG_PAGE, op_addr[3:0]};
      default: ea = op_ptr_sel ? second_pointer : first_pointer;
    endcase
  end

  // Operation capture
  always_ff @(posedge clk) begin
    if (reset) begin
      cur_op <= op_load_acc;
      cur_mode <= mode_indirect;
      cur_post <= post_none;
      cur_ptr_sel <= 1'b0;
      cur_imm <= 8'h00;
      cur_ea <= 8'h00;
      cur_bit <= 3'h0;
      cur_disp <= 7'sd0;
      cur_target <= 15'h0000;
      cur_ret <= PC_RESET;
      cur_internal <= 1'b0;
      cur_from_mem <= 1'b0;
      cur_from_rom <= 1'b0;
      hold <= 8'h00;
    end else if (accept) begin
      cur_op <= op_code;
      cur_mode <= op_mode;
      cur_post <= op_post;
      cur_ptr_sel <= op_ptr_sel;
      cur_imm <= op_imm;
      cur_ea <= ea;
      cur_bit <= op_bit;
      cur_disp <= op_disp;
      cur_target <= op_target;
      cur_ret <= pc_plus(program_counter, op_len);
      cur_internal <= (op_mode != mode_immediate) && is_internal(ea);
      cur_from_mem <= acc_read && !is_internal(ea);
      cur_from_rom <= (op_code == op_load_acc_from_rom) || (op_code == op_jump_via_table);
      // Pointer page is held here, so its bytes never reach data memory
      case (ea)
        ADDR_FIRST: hold <= first_pointer;
        ADDR_SECOND: hold <= second_pointer;
        ADDR_STACK: hold <= stack_pointer;
        default: hold <= op_imm;
      endcase
      if (op_mode == mode_immediate) begin
        hold <= op_imm;
      end
    end
  end

  // Sequencing and memory strobes
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= s_idle;
      op_ready <= 1'b1;
      op_done <= 1'b0;
      dmem_addr <= 8'h00;
      dmem_rd <= 1'b0;
      dmem_wr <= 1'b0;
      dmem_wdata <= 8'h00;
      pmem_addr <= PC_RESET;
      pmem_rd <= 1'b0;
    end else begin
      op_done <= 1'b0;
      case (state)
        s_idle: begin
          if (accept) begin
            if (skip_next) begin
              op_done <= 1'b1;
            end else if ((op_code == op_load_acc_from_rom) || (op_code == op_jump_via_table)) begin
              pmem_addr <= {program_counter[PC_W-1:LOW_W], accumulator};
              pmem_rd <= 1'b1;
              op_ready <= 1'b0;
              state <= s_wait;
            end else if (acc_read && !is_internal(ea)) begin
              dmem_addr <= ea;
              dmem_rd <= 1'b1;
              op_ready <= 1'b0;
              state <= s_wait;
            end else begin
              op_ready <= 1'b0;
              state <= s_exec;
            end
          end
        end
        s_wait: begin
          dmem_rd <= 1'b0;
          pmem_rd <= 1'b0;
          state <= s_exec;
        end
        s_exec: begin
          if (is_call) begin
            dmem_addr <= stack_pointer;
            dmem_wdata <= cur_ret[LOW_W-1:0];
            dmem_wr <= 1'b1;
            state <= s_push;
          end else if (ex_wr && !cur_internal) begin
            dmem_addr <= cur_ea;
            dmem_wdata <= ex_res;
            dmem_wr <= 1'b1;
            state <= s_write;
          end else begin
            op_done <= 1'b1;
            op_ready <= 1'b1;
            state <= s_idle;
          end
        end
        s_push: begin
          dmem_addr <= stack_pointer - 8'h01;
          dmem_wdata <= {1'b0, cur_ret[PC_W-1:LOW_W]};
          state <= s_write;
        end
        s_write: begin
          dmem_wr <= 1'b0;
          op_done <= 1'b1;
          op_ready <= 1'b1;
          state <= s_idle;
        end
        default: state <= s_idle;
      endcase
    end
  end

  assign opnd = cur_from_rom ? pmem_rdata : (cur_from_mem ? dmem_rdata : hold);

  // Execution results
  always_comb begin
    addend = (cur_op == op_sub_borrow) ? ~opnd : opnd;
    sum9 = {1'b0, accumulator} + {1'b0, addend} + {8'h00, carry};
    sum5 = {1'b0, accumulator[3:0]} + {1'b0, addend[3:0]} + {4'h0, carry};
    hi_fix = carry || (accumulator > BCD_BYTE_MAX);
    fix = 8'h00;
    ex_res = opnd;
    ex_acc = accumulator;
    ex_acc_we = 1'b0;
    ex_flags_we = 1'b0;
    ex_c = carry;
    ex_hc = half_carry;
    ex_wr = 1'b0;
    ex_skip = 1'b0;
    ex_pc = cur_ret;
    case (cur_op)
      op_add_carry, op_sub_borrow: begin
        ex_acc = sum9[7:0];
        ex_acc_we = 1'b1;
        ex_flags_we = 1'b1;
        ex_c = sum9[8];
        ex_hc = sum5[4];
      end
      op_and: begin
        ex_acc = accumulator & opnd;
        ex_acc_we = 1'b1;
      end
      op_or: begin
        ex_acc = accumulator | opnd;
        ex_acc_we = 1'b1;
      end
      op_xor: begin
        ex_acc = accumulator ^ opnd;
        ex_acc_we = 1'b1;
      end
      op_test_equal: ex_skip = (accumulator != opnd);
      op_test_greater: ex_skip = !(accumulator > opnd);
      op_test_pointer_low_ne: ex_skip = (first_pointer[3:0] == cur_imm[3:0]);
      op_dec_reg_skip_zero: begin
        ex_res = opnd - 8'h01;
        ex_wr = 1'b1;
        ex_skip = (ex_res == 8'h00);
      end
      op_set_mem_bit: begin
        ex_res = opnd | (8'h01 << cur_bit);
        ex_wr = 1'b1;
      end
      op_clear_mem_bit: begin
        ex_res = opnd & ~(8'h01 << cur_bit);
        ex_wr = 1'b1;
      end
      op_test_mem_bit: ex_skip = !opnd[cur_bit];
      op_load_acc, op_load_acc_from_rom: begin
        ex_acc = opnd;
        ex_acc_we = 1'b1;
      end
      op_load_mem_imm: begin
        ex_res = cur_imm;
        ex_wr = 1'b1;
      end
      op_exchange: begin
        ex_res = accumulator;
        ex_acc = opnd;
        ex_acc_we = 1'b1;
        ex_wr = 1'b1;
      end
      op_jump_short_rel: begin
        // Out-of-range displacements fall through as a plain advance
        if ((cur_disp >= DISP_MIN) && (cur_disp <= DISP_MAX)) begin
          ex_pc = program_counter + {{8{cur_disp[6]}}, cur_disp};
        end
      end
      op_jump_absolute, op_call_absolute: ex_pc = {program_counter[PC_W-1:ABS_W], cur_target[ABS_W-1:0]};
      op_jump_long, op_call_long: ex_pc = cur_target;
      op_jump_via_table: ex_pc = {program_counter[PC_W-1:LOW_W], opnd};
      op_decimal_adjust: begin
        if (last_sub) begin
          fix = {carry ? 4'h0 : BCD_HIGH_FIX[7:4], half_carry ? 4'h0 : BCD_LOW_FIX[3:0]};
          ex_acc = accumulator - fix;
        end else begin
          fix = {hi_fix ? BCD_HIGH_FIX[7:4] : 4'h0,
                 (half_carry || (accumulator[3:0] > BCD_DIGIT_MAX)) ? BCD_LOW_FIX[3:0] : 4'h0};
          ex_acc = accumulator + fix;
          ex_c = hi_fix;
        end
        ex_acc_we = 1'b1;
      end
      default: ex_res = opnd;
    endcase
  end

  // Accumulator and carry flags
  always_ff @(posedge clk) begin
    if (reset) begin
      accumulator <= ACC_RESET;
      carry <= 1'b0;
      half_carry <= 1'b0;
      last_sub <= 1'b0;
    end else if (state == s_exec) begin
      if (ex_acc_we) begin
        accumulator <= ex_acc;
      end
      if (ex_flags_we) begin
        half_carry <= ex_hc;
        last_sub <= (cur_op == op_sub_borrow);
      end
      if (ex_flags_we || (cur_op == op_decimal_adjust)) begin
        carry <= ex_c;
      end
    end
  end

  // Pointer page
  always_ff @(posedge clk) begin
    if (reset) begin
      first_pointer <= PTR_RESET;
      second_pointer <= PTR_RESET;
      stack_pointer <= STACK_RESET;
    end else if (state == s_exec) begin
      if (ex_wr && cur_internal) begin
        case (cur_ea)
          ADDR_FIRST: first_pointer <= ex_res;
          ADDR_SECOND: second_pointer <= ex_res;
          default: stack_pointer <= ex_res;
        endcase
      end
      if (cur_op == op_load_ptr_short) begin
        first_pointer <= {4'h0, cur_imm[SHORT_W-1:0]};
      end
      // Post step happens after the access, never before
      if (((cur_op == op_load_acc) || (cur_op == op_exchange) || (cur_op == op_load_mem_imm))
          && (cur_mode == mode_indirect) && (cur_post != post_none)) begin
        if (cur_ptr_sel) begin
          second_pointer <= (cur_post == post_inc) ? second_pointer + 8'h01 : second_pointer - 8'h01;
        end else begin
          first_pointer <= (cur_post == post_inc) ? first_pointer + 8'h01 : first_pointer - 8'h01;
        end
      end
    end else if ((state == s_write) && is_call) begin
      stack_pointer <= stack_pointer - 8'h02;
    end
  end

  // Program counter and pending skip
  always_ff @(posedge clk) begin
    if (reset) begin
      program_counter <= PC_RESET;
      skip_next <= 1'b0;
    end else if ((state == s_idle) && accept && skip_next) begin
      program_counter <= pc_plus(program_counter, op_len);
      skip_next <= 1'b0;
    end else if (state == s_exec) begin
      program_counter <= ex_pc;
      skip_next <= ex_skip;
    end
  end
endmodule

// file: tb/cobadr_mem.sv
// Data and program memory model facing the addressing core.
// Assumes the core's one-cycle read timing; released read lines flip each cycle.
`timescale 1ns/10ps
module cobadr_mem (
  // Clock
  input wire logic clk,
  // Data memory
  input wire logic [7:0] dmem_addr,
  input wire logic dmem_rd,
  input wire logic dmem_wr,
  input wire logic [7:0] dmem_wdata,
  output logic [7:0] dmem_rdata,
  // Program memory
  input wire logic [14:0] pmem_addr,
  input wire logic pmem_rd,
  output logic [7:0] pmem_rdata
);
  logic [7:0] mem [256];
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i * 37);
    dmem_rdata = 8'h00;
    pmem_rdata = 8'h00;
  end
  // Stale data is inverted so a late sample cannot pass by luck
  always @(posedge clk) begin
    dmem_rdata <= dmem_rd ? mem[dmem_addr] : ~dmem_rdata;
    pmem_rdata <= pmem_rd ? pmem_addr[7:0] ^ {1'b0, pmem_addr[14:8]} : ~pmem_rdata;
    if (dmem_wr) mem[dmem_addr] <= dmem_wdata;
  end
endmodule

// file: tb/cobadr_core_chk.sv
// Port-level checker of the addressing core.
// Bound into cobadr_core; sees its ports only.
`timescale 1ns/10ps
module cobadr_core_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Operation port
  input wire logic op_valid,
  input wire logic op_ready,
  input wire cobadr_pkg::cobadr_op_t op_code,
  input wire cobadr_pkg::cobadr_mode_t op_mode,
  input wire logic op_ptr_sel,
  input wire cobadr_pkg::cobadr_post_t op_post,
  input wire logic [7:0] op_addr,
  input wire logic signed [6:0] op_disp,
  input wire logic [14:0] op_target,
  input wire logic [1:0] op_len,
  input wire logic op_done,
  input wire logic skip_next,
  // Memories
  input wire logic [7:0] dmem_addr,
  input wire logic dmem_rd,
  input wire logic [14:0] pmem_addr,
  input wire logic pmem_rd,
  input wire logic [7:0] pmem_rdata,
  // State
  input wire logic [14:0] program_counter,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] first_pointer,
  input wire logic [7:0] second_pointer
);
  import cobadr_pkg::*;
  logic run, rd_op, tk_sel;
  logic [7:0] ptr, tk_ptr, tk_acc;
  logic [14:0] tk_pc, tk_tgt, tk_rel;
  logic [1:0] tk_len;
  assign run = op_valid && op_ready && !skip_next;
  assign ptr = op_ptr_sel ? second_pointer : first_pointer;
  assign rd_op = op_code inside {op_add_carry, op_sub_borrow, op_and, op_or, op_xor, op_test_equal, op_load_acc};
  always_ff @(posedge clk) begin
    if (op_valid && op_ready) begin
      tk_pc <= program_counter;
      tk_acc <= accumulator;
      tk_sel <= op_ptr_sel;
      tk_ptr <= ptr;
      tk_len <= op_len;
      tk_tgt <= op_target;
      tk_rel <= program_counter + {{8{op_disp[6]}}, op_disp};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_skip_only_pc: assert property (op_valid && op_ready && skip_next |=> op_done
    && program_counter == tk_pc + 15'(tk_len) && accumulator == tk_acc) else $error("skipped op bad");
  a_direct_addr: assert property (run && rd_op && op_mode == mode_direct && op_addr[7:4] != 4'hf
    |=> dmem_rd && dmem_addr == $past(op_addr)) else $error("direct address bad");
  a_indirect_addr: assert property (run && rd_op && op_mode == mode_indirect && ptr[7:4] != 4'hf
    |=> dmem_rd && dmem_addr == tk_ptr) else $error("indirect address bad");
  a_post_step: assert property (run && op_code == op_load_acc && op_mode == mode_indirect
    && op_post == post_inc && ptr[7:4] != 4'hf
    |-> ##3 op_done && (tk_sel ? second_pointer : first_pointer) == tk_ptr + 8'h01) else $error("post step bad");
  a_rel_jump: assert property (run && op_code == op_jump_short_rel && op_disp >= -7'sd31
    && op_disp <= 7'sd32 && op_disp != 7'sd1 |-> ##2 op_done && program_counter == tk_rel) else $error("rel bad");
  a_abs_jump: assert property (run && op_code == op_jump_absolute
    |-> ##2 op_done && program_counter == {tk_pc[14:12], tk_tgt[11:0]}) else $error("abs jump bad");
  a_long_jump: assert property (run && op_code == op_jump_long
    |-> ##2 op_done && program_counter == tk_tgt) else $error("long jump bad");
  a_rom_addr: assert property (run && op_code inside {op_jump_via_table, op_load_acc_from_rom}
    |=> pmem_rd && pmem_addr == {tk_pc[14:8], tk_acc}) else $error("rom address bad");
  a_table_load: assert property (run && op_code == op_jump_via_table
    |-> ##3 op_done && program_counter == {tk_pc[14:8], $past(pmem_rdata)}) else $error("table jump bad");
endmodule
bind cobadr_core cobadr_core_chk i_chk (.clk, .reset, .op_valid, .op_ready, .op_code, .op_mode, .op_ptr_sel,
  .op_post, .op_addr, .op_disp, .op_target, .op_len, .op_done, .skip_next, .dmem_addr, .dmem_rd, .pmem_addr,
  .pmem_rd, .pmem_rdata, .program_counter, .accumulator, .first_pointer, .second_pointer);

// file: tb/cobadr_core_tb.sv
// Self-checking bench: integer model of the core compared at every completion.
// Assumes cobadr_mem as both memories and the bound checker.
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module cobadr_core_tb;
  import cobadr_pkg::*;
  logic clk, reset, op_valid, op_ready, op_ptr_sel, op_done, skip_next, dmem_rd, dmem_wr, pmem_rd, carry, half_carry;
  logic [7:0] op_imm, op_addr, dmem_addr, dmem_wdata, dmem_rdata, pmem_rdata;
  logic [7:0] accumulator, first_pointer, second_pointer, stack_pointer;
  logic [14:0] op_target, pmem_addr, program_counter;
  logic [2:0] op_bit;
  logic [1:0] op_len;
  logic signed [6:0] op_disp;
  logic [15:0] seed;
  cobadr_op_t op_code;
  cobadr_mode_t op_mode;
  cobadr_post_t op_post;
  int error_cnt, samples_checked, m_acc, m_c, m_hc, m_pc, m_fp, m_sp2, m_skip, m_sub, m_spk;
  int dm [256];
  cobadr_op_t ops [24] = '{op_add_carry, op_sub_borrow, op_and, op_or, op_xor, op_test_equal, op_test_greater,
    op_test_pointer_low_ne, op_dec_reg_skip_zero, op_set_mem_bit, op_clear_mem_bit, op_test_mem_bit, op_load_acc,
    op_load_ptr_short, op_load_acc_from_rom, op_jump_short_rel, op_jump_absolute, op_jump_long, op_jump_via_table,
    op_decimal_adjust, op_exchange, op_load_mem_imm, op_call_absolute, op_call_long};
  cobadr_core i_dut (.clk, .reset, .op_valid, .op_ready, .op_code, .op_mode, .op_ptr_sel, .op_post, .op_imm,
    .op_addr, .op_bit, .op_disp, .op_target, .op_len, .op_done, .skip_next, .dmem_addr, .dmem_rd, .dmem_wr,
    .dmem_wdata, .dmem_rdata, .pmem_addr, .pmem_rd, .pmem_rdata, .program_counter, .accumulator, .carry,
    .half_carry, .first_pointer, .second_pointer, .stack_pointer);
  cobadr_mem i_mem (.clk, .dmem_addr, .dmem_rd, .dmem_wr, .dmem_wdata, .dmem_rdata, .pmem_addr, .pmem_rd,
    .pmem_rdata);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic do_op(cobadr_op_t o, cobadr_mode_t m, int s, cobadr_post_t p, int im, ad, b, d, t, l);
    int a, v, r, oc, n, k;
    a = m == mode_direct ? ad : m == mode_reg ? 240 + ad : s ? m_sp2 : m_fp;
    // Pointer page bytes live in the core, not in data memory
    v = m == mode_immediate ? im : a == ADDR_FIRST ? m_fp : a == ADDR_SECOND ? m_sp2 : a == ADDR_STACK ? m_spk : dm[a];
    oc = m_pc + l;
    r = m_pc & 32512 | m_acc;
    r = r & 255 ^ r >> 8;
    if (m_skip) m_skip = 0;
    else begin
      case (o)
        op_add_carry, op_sub_borrow: begin
          v = o == op_sub_borrow ? v ^ 255 : v;
          m_hc = (m_acc & 15) + (v & 15) + m_c > 15;
          m_acc = m_acc + v + m_c;
          m_c = m_acc > 255;
          m_acc &= 255;
          m_sub = o == op_sub_borrow;
        end
        op_and: m_acc &= v;
        op_or: m_acc |= v;
        op_xor: m_acc ^= v;
        op_test_equal: m_skip = m_acc != v;
        op_test_greater: m_skip = m_acc <= v;
        op_test_pointer_low_ne: m_skip = (m_fp & 15) == (im & 15);
        op_dec_reg_skip_zero: begin
          dm[a] = (v + 255) & 255;
          m_skip = dm[a] == 0;
        end
        op_set_mem_bit: dm[a] = v | 1 << b;
        op_clear_mem_bit: dm[a] = v & ~(1 << b);
        op_test_mem_bit: m_skip = !v[b];
        op_load_acc: m_acc = v;
        op_load_ptr_short: m_fp = im & 15;
        op_load_acc_from_rom: m_acc = r;
        op_jump_short_rel: oc = m_pc + d;
        op_jump_absolute: oc = m_pc & 28672 | t & 4095;
        op_jump_long: oc = t;
        op_jump_via_table: oc = m_pc & 32512 | r;
        op_exchange: begin
          dm[a] = m_acc;
          m_acc = v;
        end
        op_load_mem_imm: dm[a] = im;
        op_call_absolute, op_call_long: begin
          dm[m_spk] = oc & 255;
          dm[(m_spk + 255) & 255] = (oc & 32767) >> 8;
          m_spk = (m_spk + 254) & 255;
          oc = o == op_call_long ? t : m_pc & 28672 | t & 4095;
        end
        op_decimal_adjust: begin
          if (m_sub) m_acc -= (m_hc ? 0 : 6) + (m_c ? 0 : 96);
          else begin
            r = m_c || m_acc > 153;
            m_acc += (r ? 96 : 0) + (m_hc || (m_acc & 15) > 9 ? 6 : 0);
            m_c = r;
          end
          m_acc &= 255;
        end
        default: ;
      endcase
      if (o inside {op_load_acc, op_exchange, op_load_mem_imm} && m == mode_indirect && p != post_none) begin
        r = p == post_inc ? 1 : 255;
        if (s) m_sp2 = (m_sp2 + r) & 255;
        else m_fp = (m_fp + r) & 255;
      end
    end
    m_pc = oc & 32767;
    op_code = o;
    op_mode = m;
    op_ptr_sel = s[0];
    op_post = p;
    op_imm = 8'(im);
    op_addr = 8'(ad);
    op_bit = 3'(b);
    op_disp = 7'(d);
    op_target = 15'(t);
    op_len = 2'(l);
    op_valid = 1'b1;
    @(negedge clk);
    op_valid = 1'b0;
    for (n = 0; n < 8 && op_done !== 1'b1; n++) @(negedge clk);
    `CHK(op_done, 1'b1)
    `CHK(accumulator, 8'(m_acc))
    `CHK({carry, half_carry}, 2'(m_c * 2 + m_hc))
    `CHK(program_counter, 15'(m_pc))
    `CHK({first_pointer, second_pointer}, 16'(m_fp * 256 + m_sp2))
    `CHK(skip_next, 1'(m_skip))
    `CHK(i_mem.mem[a], 8'(dm[a]))
    k = (m_spk + 1) & 255;
    `CHK(stack_pointer, 8'(m_spk))
    `CHK({i_mem.mem[k], i_mem.mem[8'(k + 1)]}, 16'(dm[k] * 256 + dm[(k + 1) & 255]))
  endtask
  task automatic dir(cobadr_op_t o, int im, d, t);
    do_op(o, mode_immediate, 0, post_none, im, 0, 0, d, t, 1);
  endtask
  initial begin
    #200000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    cobadr_op_t o;
    cobadr_mode_t m;
    int s, d;
    op_valid = 1'b0;
    op_code = op_add_carry;
    op_mode = mode_direct;
    op_post = post_none;
    {op_ptr_sel, op_imm, op_addr, op_bit, op_disp, op_target, op_len} = '0;
    {m_acc, m_c, m_hc, m_pc, m_fp, m_sp2, m_skip, m_sub} = '0;
    m_spk = STACK_RESET;
    for (int i = 0; i < 256; i++) dm[i] = i * 37 & 255;
    seed = 16'h000f;
    reset = 1'b1;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    dir(op_load_ptr_short, 255, 0, 0);
    dir(op_jump_long, 0, 0, 32752);
    dir(op_jump_short_rel, 0, 32, 0);
    dir(op_jump_short_rel, 0, -31, 0);
    dir(op_jump_absolute, 0, 0, 2748);
    dir(op_add_carry, 153, 0, 0);
    dir(op_decimal_adjust, 0, 0, 0);
    dir(op_sub_borrow, 1, 0, 0);
    dir(op_decimal_adjust, 0, 0, 0);
    dir(op_test_pointer_low_ne, 15, 0, 0);
    dir(op_xor, 255, 0, 0);
    dir(op_jump_via_table, 0, 0, 0);
    do_op(op_load_acc, mode_direct, 0, post_none, 0, 254, 0, 0, 0, 2);
    $display("test directed done");
    repeat (600) begin
      o = ops[rnd() % 24];
      m = cobadr_mode_t'(rnd() % 3);
      s = rnd() % 2;
      d = rnd() % 63;
      d = d - 31 + (d > 31);
      if (o inside {op_set_mem_bit, op_clear_mem_bit, op_test_mem_bit, op_exchange, op_load_mem_imm}
          && m == mode_immediate) m = mode_direct;
      if (m == mode_indirect && (s ? m_sp2 : m_fp) > 239) m = mode_direct;
      if (o == op_dec_reg_skip_zero) m = mode_reg;
      do_op(o, m, s, cobadr_post_t'(rnd() % 3), rnd() % 256, m == mode_reg ? rnd() % 12 : rnd() % 128,
        rnd() % 8, d, rnd() % 32768, rnd() % 3 + 1);
    end
    $display("test random done");
    report_and_stop;
  end
endmodule
